// ==== sgd_fifo.sv ====
// package of shared constants and the data-path fifo of the grid driver
`default_nettype none

package sgd_pkg;
   localparam int DISP_BITS    = 20;    // shift stages and display outputs
   localparam int FIFO_DEPTH   = 8;     // words held between sampler and shifter
   localparam int ENT_W        = 2;     // fifo entry width
   localparam int ENT_DATA_POS = 0;     // serial bit carried by a shift entry
   localparam int ENT_KIND_POS = 1;     // 1 marks a latch command entry
   localparam int SYS_CLK_NS   = 10;    // system clock period
   localparam int T_CDO_NS     = 500;   // longest clock-low to data-out time
   localparam int CDO_CYC      = T_CDO_NS / SYS_CLK_NS;  // rounded down
   localparam logic [ENT_W-1:0] ENT_LATCH = 2'h2;  // latch command entry
endpackage : sgd_pkg

// small synchronous fifo, valid/ready on both sides
module sgd_fifo #(
   parameter int WIDTH = sgd_pkg::ENT_W,
   parameter int DEPTH = sgd_pkg::FIFO_DEPTH
) (
   input  wire logic             i_clk_sys,  // system clock
   input  wire logic             i_nrst,     // sync reset, active low
   input  wire logic             i_ce,       // clock enable
   input  wire logic             i_wvalid,   // write request
   output logic                  o_wready,   // room for one word
   input  wire logic [WIDTH-1:0] i_wdata,    // word to store
   output logic                  o_rvalid,   // a word is available
   input  wire logic             i_rready,   // reader takes the word
   output logic      [WIDTH-1:0] o_rdata     // oldest word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem      [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [AW-1:0]    wptr, next_wptr, rptr, next_rptr;
   logic [CW-1:0]    count, next_count;
   logic             push, pop;

   // pointer advance with wrap at depth
   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign o_wready = (count != CW'(DEPTH));
   assign o_rvalid = (count != '0);
   assign o_rdata  = mem[rptr];
   assign push     = i_wvalid & o_wready;
   assign pop      = o_rvalid & i_rready;

   // next storage, pointers and fill level
   always_comb begin
      next_mem = mem;
      next_wptr = wptr;
      next_rptr = rptr;
      next_count = count;
      if (push) begin
         next_mem[wptr] = i_wdata;
         next_wptr = ptr_inc(wptr);
      end
      if (pop) begin
         next_rptr = ptr_inc(rptr);
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   // register fifo state
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         wptr  <= '0;
         rptr  <= '0;
         count <= '0;
         for (int k = 0; k < DEPTH; k++) begin
            mem[k] <= '0;
         end
      end else if (i_ce) begin
         wptr  <= next_wptr;
         rptr  <= next_rptr;
         count <= next_count;
         mem   <= next_mem;
      end
   end
endmodule : sgd_fifo // sgd_fifo

`default_nettype wire

// ==== sgd_driver.sv ====
// serial-in grid driver: sampler, fifo, shift register, latch and blanking
//
// Notes on behaviour
// R1: serial clock edges count only while enable is high.
// R2: each rising serial clock edge samples data and shifts one stage.
// R3: enable falling copies the whole shift register into the output latch.
// R4: display keeps the old latched pattern while bits are shifting.
// R5: bit leaving the shift register appears on data out at falling clock.
// R6: blanking may be asserted any time and blanks the display.
// R7: host clears by shifting 20 zeroes under enable, then dropping enable.
// R8: host should run the zero flush after power-up.
// R9: shift register and latch hold 20 bits; one turns an output on.
// R10: blanking forces outputs off, keeps register and latch, release restores.
`default_nettype none

module sgd_driver #(
   parameter int N     = sgd_pkg::DISP_BITS,   // display outputs
   parameter int DEPTH = sgd_pkg::FIFO_DEPTH   // fifo words
) (
   input  wire logic         i_clk_sys,  // 100 MHz system clock
   input  wire logic         i_nrst,     // sync reset, active low
   input  wire logic         i_ce,       // clock enable, freezes all state
   input  wire logic         i_sclk,     // serial clock pin
   input  wire logic         i_din,      // serial data pin
   input  wire logic         i_enable,   // load envelope pin
   input  wire logic         i_blank,    // blanking control pin
   output logic              o_dout,     // cascade serial data out
   output logic [N-1:0]      o_disp,     // display outputs, 1 = on
   output logic              o_in_ready, // fifo has room for sampled events
   output logic              o_overrun   // sticky: a sampled event was lost
);
   // synchroniser stages and edge history
   logic sclk_m, sclk_s, sclk_d;
   logic din_m, din_s;
   logic en_m, en_s, en_d;
   logic blk_m, blk_s;

   // datapath state
   logic [N-1:0] shreg, next_shreg;
   logic [N-1:0] latch, next_latch;
   logic [N-1:0] next_disp;
   logic         hold, next_hold;
   logic         next_dout, next_overrun;

   // fifo handshakes
   logic                         wvalid, wready, rvalid, rready;
   logic [sgd_pkg::ENT_W-1:0]    wdata, rdata;
   logic                         clk_rise, clk_fall, en_fall;
   logic                         pop_bit, pop_latch;

   // two-flop synchronisers, first stage read only by the second
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         sclk_d <= 1'b0;
         din_m  <= 1'b0;
         din_s  <= 1'b0;
         en_m   <= 1'b0;
         en_s   <= 1'b0;
         en_d   <= 1'b0;
         blk_m  <= 1'b0;
         blk_s  <= 1'b0;
      end else if (i_ce) begin
         sclk_m <= i_sclk;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         din_m  <= i_din;
         din_s  <= din_m;
         en_m   <= i_enable;
         en_s   <= en_m;
         en_d   <= en_s;
         blk_m  <= i_blank;
         blk_s  <= blk_m;
      end
   end

   // edge detection on synchronised pins
   assign clk_rise = sclk_s & ~sclk_d;
   assign clk_fall = ~sclk_s & sclk_d;
   assign en_fall  = ~en_s & en_d;

   // sampled events into the fifo: bits under enable, latch on enable fall
   always_comb begin
      wvalid = 1'b0;
      wdata  = '0;
      if (en_fall) begin
         wvalid = 1'b1;                          // [R3]
         wdata  = sgd_pkg::ENT_LATCH;
      end else if (clk_rise && en_s) begin       // [R1]
         wvalid = 1'b1;                          // [R2]
         wdata  = {1'b0, din_s};
      end
   end

   sgd_fifo #(
      .WIDTH (sgd_pkg::ENT_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .i_ce      (i_ce),
      .i_wvalid  (wvalid),
      .o_wready  (wready),
      .i_wdata   (wdata),
      .o_rvalid  (rvalid),
      .i_rready  (rready),
      .o_rdata   (rdata)
   );

   // drain side stalls one cycle after each latch update
   assign rready    = ~hold;
   assign pop_bit   = rvalid & rready & ~rdata[sgd_pkg::ENT_KIND_POS];
   assign pop_latch = rvalid & rready & rdata[sgd_pkg::ENT_KIND_POS];

   // next shift register, latch, display and cascade output
   always_comb begin
      next_shreg   = shreg;
      next_latch   = latch;
      next_hold    = 1'b0;
      next_dout    = o_dout;
      next_overrun = o_overrun | (wvalid & ~wready);
      if (pop_bit) begin
         next_shreg = {shreg[N-2:0], rdata[sgd_pkg::ENT_DATA_POS]};  // [R2] [R9]
      end
      if (pop_latch) begin
         next_latch = shreg;                     // [R3] [R4]
         next_hold  = 1'b1;
      end
      if (clk_fall && en_s) begin
         next_dout = shreg[N-1];                 // [R5] [R1]
      end
      next_disp = blk_s ? '0 : latch;            // [R6] [R10] [R9]
   end

   // register datapath state and outputs
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         shreg      <= '0;
         latch      <= '0;
         hold       <= 1'b0;
         o_dout     <= 1'b0;
         o_disp     <= '0;
         o_in_ready <= 1'b0;
         o_overrun  <= 1'b0;
      end else if (i_ce) begin
         shreg      <= next_shreg;
         latch      <= next_latch;
         hold       <= next_hold;
         o_dout     <= next_dout;
         o_disp     <= next_disp;
         o_in_ready <= wready;
         o_overrun  <= next_overrun;
      end
   end

   // checks, suspended in reset and while the clock enable is low
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst || !i_ce);

   AST_R1_IGNORE_IDLE_CLK: assert property ( // [R1]
      (clk_rise && !en_s && !en_fall) |-> !wvalid)
      else $error("serial clock edge accepted with enable low");

   AST_R2_SAMPLE_BIT: assert property ( // [R2]
      (clk_rise && en_s) |-> (wvalid && wdata == {1'b0, din_s}))
      else $error("rising clock under enable did not sample data");

   AST_R2_SHIFT: assert property ( // [R2]
      pop_bit |=> shreg == {$past(shreg[N-2:0]), $past(rdata[sgd_pkg::ENT_DATA_POS])})
      else $error("shift register did not advance by one stage");

   AST_R3_LATCH_COPY: assert property ( // [R3]
      pop_latch |=> (latch == $past(shreg)) ##1 ($past(blk_s) || o_disp == $past(latch)))
      else $error("latch did not take shift register on enable fall");

   AST_R3_FALL_QUEUED: assert property ( // [R3]
      (en_fall && wready) |-> (wvalid && wdata == sgd_pkg::ENT_LATCH))
      else $error("enable fall did not queue a latch command");

   AST_R4_HOLD_OLD: assert property ( // [R4]
      !pop_latch |=> $stable(latch))
      else $error("latch changed without a latch command");

   AST_R5_DOUT: assert property ( // [R5]
      (clk_fall && en_s) |=> (o_dout == $past(shreg[N-1])))
      else $error("data out not updated at falling clock");

   AST_R5_DOUT_HOLD: assert property ( // [R5]
      !(clk_fall && en_s) |=> $stable(o_dout))
      else $error("data out changed without a falling clock under enable");

   AST_R4_DISP_STEADY: assert property ( // [R4]
      (!blk_s && !$past(blk_s) && !$past(pop_latch)) |=> $stable(o_disp))
      else $error("display changed without a latch update");

   AST_R9_DISP_FOLLOWS: assert property ( // [R9]
      !blk_s |=> (o_disp == $past(latch)))
      else $error("display does not show the latched pattern");

   AST_R10_KEEP_STATE: assert property ( // [R10]
      (blk_s && !pop_bit && !pop_latch) |=> ($stable(shreg) && $stable(latch)))
      else $error("blanking altered shift register or latch");

   AST_R6_BLANK: assert property ( // [R6]
      blk_s |=> (o_disp == '0))
      else $error("display not blanked");

   AST_R10_RESTORE: assert property ( // [R10]
      (!blk_s && $past(blk_s)) |=> (o_disp == $past(latch)))
      else $error("latched pattern not restored after blanking");

   AST_R9_ONLY_LATCHED_ON: assert property ( // [R9]
      ##1 ((o_disp & ~$past(latch)) == '0))
      else $error("output on without a latched one");

   COV_LATCH: cover property (pop_latch ##2 (o_disp != '0));
   COV_BLANK: cover property (blk_s ##1 !blk_s ##1 (o_disp != '0));
   COV_FULL:  cover property (!wready ##1 wready);
   COV_DOUT:  cover property ((clk_fall && en_s && shreg[N-1]) ##1 o_dout);
endmodule : sgd_driver // sgd_driver

`default_nettype wire

// ==== sgd_host_model.sv ====
// host model that drives the serial link of the grid driver
`default_nettype none

module sgd_host_model (
   input  wire logic i_clk_sys,  // system clock
   input  wire logic i_dout,     // cascade data from the driver
   output var logic  o_sclk,     // serial clock, still outside frames
   output var logic  o_din,      // serial data
   output var logic  o_enable,   // load envelope
   output var logic  o_blank     // blanking
);
   timeunit 1ns;
   timeprecision 1ns;

   logic cap[$];  // data out seen just before each rising clock

   // quiet pins from time zero
   initial begin
      o_sclk = 1'b0;
      o_din = 1'b0;
      o_enable = 1'b0;
      o_blank = 1'b0;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask

   // n bits msb first, half = cycles per clock phase, en = envelope level
   task automatic frame(input logic [39:0] s, input int n, input int half, input logic en);
      o_enable <= en;
      cyc(10);
      for (int i = n - 1; i >= 0; i--) begin
         o_din <= s[i];
         cyc(half - 2);
         cap.push_back(i_dout);
         o_sclk <= 1'b1;
         cyc(half);
         o_sclk <= 1'b0;
         cyc(2);
      end
      cyc(10);
      o_enable <= 1'b0;
      o_din <= ~o_din;  // toggled, line no longer meaningful
      cyc(10);
   endtask

   task automatic set_blank(input logic v);
      o_blank <= v;
   endtask
endmodule  // sgd_host_model

`default_nettype wire

// ==== tb.sv ====
// testbench of the grid driver: loads, envelope, cascade, blanking, clear
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic      i_clk_sys = 1'b0;
   logic      i_nrst = 1'b0;
   logic      i_ce = 1'b1;
   wire logic sclk, din, en, blank, dout, in_ready, overrun;
   wire logic [sgd_pkg::DISP_BITS-1:0] disp;
   int        fails = 0;
   int        check_count = 0;

   always #5 i_clk_sys = ~i_clk_sys;

   sgd_host_model u_host (.i_clk_sys(i_clk_sys), .i_dout(dout), .o_sclk(sclk),
      .o_din(din), .o_enable(en), .o_blank(blank));

   sgd_driver u_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce), .i_sclk(sclk),
      .i_din(din), .i_enable(en), .i_blank(blank), .o_dout(dout), .o_disp(disp),
      .o_in_ready(in_ready), .o_overrun(overrun));

   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // bounded wait for a display pattern, runs out to the report
   task automatic wait_disp(input logic [19:0] exp);
      for (int k = 0; k < 40 && disp !== exp; k++) @(posedge i_clk_sys);
      chk("display", exp, disp);
      if (disp !== exp)
         tally_and_finish();
   endtask

   // reset state, then a first full load
   task automatic t_load;
      chk("reset display", 20'h0, disp);
      chk("ready", 20'h1, {19'h0, in_ready});
      u_host.frame({20'h0, 20'ha5c3f}, 20, 8, 1'b1);
      wait_disp(20'ha5c3f);
   endtask

   // slow host; old pattern stays up while bits move
   task automatic t_hold;
      fork
         u_host.frame({20'h0, 20'h0f0f1}, 20, 30, 1'b1);
         begin
            u_host.cyc(300);
            chk("display while shifting", 20'ha5c3f, disp);
         end
      join
      wait_disp(20'h0f0f1);
   endtask

   // clocks outside the envelope must not shift
   task automatic t_ignore;
      u_host.frame(40'hfffff, 5, 8, 1'b0);
      u_host.frame(40'h0, 0, 8, 1'b1);
      chk("display after empty load", 20'h0f0f1, disp);
   endtask

   // 40 bits: old and first bits leave on data out in order
   task automatic t_cascade;
      logic [59:0] full;
      full = {20'h0f0f1, 20'h3c96e, 20'h52b7d};
      u_host.cap.delete();
      u_host.frame(full[39:0], 40, 8, 1'b1);
      for (int j = 0; j < 40; j++)
         chk("data out", {19'h0, full[59-j]}, {19'h0, u_host.cap[j]});
      wait_disp(20'h52b7d);
   endtask

   // blank, load under blank, release shows latch
   task automatic t_blank;
      u_host.set_blank(1'b1);
      wait_disp(20'h0);
      u_host.frame({20'h0, 20'h81e24}, 20, 8, 1'b1);
      chk("blanked display", 20'h0, disp);
      u_host.set_blank(1'b0);
      wait_disp(20'h81e24);
   endtask

   // clock enable low freezes all state: a blank pulse while frozen is never seen
   task automatic t_freeze;
      i_ce <= 1'b0;
      u_host.set_blank(1'b1);
      u_host.cyc(10);
      chk("display while frozen", 20'h81e24, disp);
      u_host.set_blank(1'b0);
      u_host.cyc(5);
      i_ce <= 1'b1;
      u_host.cyc(5);
      chk("display after freeze", 20'h81e24, disp);
   endtask

   // zero flush clears the display
   task automatic t_clear;
      u_host.frame(40'h0, 20, 8, 1'b1);
      wait_disp(20'h0);
      chk("overrun", 20'h0, {19'h0, overrun});
   endtask

   // reset, scenarios, verdict
   initial begin
      repeat (10) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      u_host.cyc(3);
      t_load();
      t_hold();
      t_ignore();
      t_cascade();
      t_blank();
      t_freeze();
      t_clear();
      tally_and_finish();
   end

   // watchdog against a hang
   initial begin
      #400000;
      fails++;
      tally_and_finish();
   end
endmodule  // tb

`default_nettype wire
